// ==== design/cidm_top.sv ====
// Purpose: CAN interrupt reporting and diagnostic modes, AXI4-Lite slave
// Assumes: Frame engine, message RAM and bit timing sit outside
// Notes: Inputs synchronous to REF_CLK (40 MHz)
`timescale 1ns/1ps
`include "cidm_cfg.svh"

// Function
// - Status first, then lowest object number
// - Object irq cleared by flag or status read
// - Status write loads code and success fields; only read clears irq
// - Identifier zero means nothing pending
// - Irq line is enable and nonzero identifier
// - Status field irq needs status enable
// - Bus-off/warning irq needs error enable
// - Identifier updates with line enable clear
// - 0x8000 on a status update whose enable is set
// - Readable per-object pending map
// - Clear-pending access advances identifier outside basic mode
// - Diagnostic functions only with test bit
// - Readable receive pin level
// - Silent: recessive out, dominant looped in
// - Loopback: tx routed to rx, still visible
// - Loopback: ignore ack error and pin
// - Loopback plus silent: rx cut, tx recessive
// - Basic: busy locks set one, sends, releases
// - Clearing busy aborts, no retransmission
// - Basic: set two captures every frame
// - Basic: set two keeps flags, length only
// - Two-bit override selects transmit pin source
module cidm_top #(
  parameter int NOBJ = 32, // Message objects
  parameter int IW = 5 // Object index width
) (
  input wire logic REF_CLK, // 40 MHz clock
  input wire logic NRST, // Async reset, low
  input wire logic [7:0] S_AXI_AWADDR, // Write address
  input wire logic S_AXI_AWVALID, // Write address valid
  output logic S_AXI_AWREADY, // Write address ready
  input wire logic [31:0] S_AXI_WDATA, // Write data
  input wire logic [3:0] S_AXI_WSTRB, // Byte enables
  input wire logic S_AXI_WVALID, // Write data valid
  output logic S_AXI_WREADY, // Write data ready
  output logic [1:0] S_AXI_BRESP, // Write response
  output logic S_AXI_BVALID, // Write response valid
  input wire logic S_AXI_BREADY, // Write response ready
  input wire logic [7:0] S_AXI_ARADDR, // Read address
  input wire logic S_AXI_ARVALID, // Read address valid
  output logic S_AXI_ARREADY, // Read address ready
  output logic [31:0] S_AXI_RDATA, // Read data
  output logic [1:0] S_AXI_RRESP, // Read response
  output logic S_AXI_RVALID, // Read data valid
  input wire logic S_AXI_RREADY, // Read data ready
  output logic IRQ, // Interrupt to processor
  input wire logic STS_UPD, // Engine writes status
  input wire logic STS_UPD_ERR, // Update is bus-off/warning kind
  input wire logic [2:0] STS_LEC, // New last error code
  input wire logic STS_TX_SUCCESS_FLAG, // New tx success
  input wire logic STS_RX_SUCCESS_FLAG, // New rx success
  input wire logic STS_ERROR_WARNING_FLAG, // New warning level
  input wire logic STS_BUS_OFF_FLAG, // New bus-off level
  input wire logic OBJ_IRQ_SET, // Object raises irq
  input wire logic [IW-1:0] OBJ_IRQ_IDX, // Object index (number-1)
  input wire logic CORE_TX, // Controller transmit bit
  input wire logic CORE_SAMPLE_PT, // Sample point marker
  output logic CORE_RX, // Receive bit to controller
  output logic CORE_SILENT, // Controller may not start frames
  output logic CORE_ACK_IGNORE, // Ignore ack errors
  input wire logic CAN_RX, // Receive pin
  output logic CAN_TX, // Transmit pin
  output logic BASIC_MODE, // Buffer-only operation
  output logic BASIC_TX_REQ, // Set one waits to be sent
  output logic BASIC_RETRY_EN, // Retransmission allowed
  output logic [31:0] IF1_DATA, // Set one transmit contents
  input wire logic BASIC_TX_LOAD, // Set one loaded at idle bus
  input wire logic BASIC_TX_DONE, // Transmission completed
  input wire logic BASIC_TX_FAIL, // Lost arbitration or error
  input wire logic BASIC_RX_DONE, // Frame received
  input wire logic [31:0] SHIFT_DATA, // Shift register contents
  input wire logic [3:0] SHIFT_DLC // Received length code
);

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // True for a mapped word offset
  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `CIDM_OFS_IF_CMD);
  endfunction

  // AXI channel state
  logic bvalid_q, bvalid_d; // Write response pending
  logic [1:0] bresp_q, bresp_d; // Write response code
  logic rvalid_q, rvalid_d; // Read data pending
  logic [1:0] rresp_q, rresp_d; // Read response code
  logic [31:0] rdata_q, rdata_d; // Read data
  logic wr_go; // Write accepted now
  logic rd_go; // Read accepted now
  logic [31:0] rd_val; // Selected read value

  // Register state
  logic [7:0] ctrl_q, ctrl_d; // Control register
  logic [7:0] sts_q, sts_d; // Status register
  logic sts_irq_q, sts_irq_d; // Status source pending
  logic [7:0] diag_q, diag_d; // Diagnostic register
  logic [31:0] if1_q, if1_d; // Set one contents
  logic [31:0] if2_q, if2_d; // Set two contents
  logic [3:0] dlc_q, dlc_d; // Set two length code
  logic new_data_flag_q, new_data_flag_d; // Set two new data
  logic message_lost_flag_q, message_lost_flag_d; // Set two lost message
  cidm_pkg::cidm_btx_e btx_q, btx_d; // Basic transmit state

  // Pending map wires
  logic [NOBJ-1:0] pend_map; // Per-object flags
  logic pend_any; // Some object pending
  logic [IW-1:0] pend_top; // Lowest pending index
  logic pclr_en; // Clear one flag
  logic [IW-1:0] pclr_idx; // Flag to clear
  logic sts_read; // Status register read

  // Effective diagnostic controls
  logic test_on; // Test bit
  logic silent_on; // Silent active
  logic loopback_enable_on; // Loopback active
  logic basic_on; // Basic active
  cidm_pkg::cidm_txo_e txo; // Pin source
  logic tx_proto; // Protocol pin value
  logic [15:0] interrupt_identifier; // Interrupt identifier
  logic [31:0] wmask; // Merged write value

  // Handshakes: address and data taken together
  assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_q;
  assign rd_go = S_AXI_ARVALID && !rvalid_q;
  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY = wr_go;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;

  // Diagnostic bits gated by the test bit
  assign test_on = ctrl_q[`CIDM_CTRL_TEST];
  assign silent_on = test_on && diag_q[`CIDM_DIAG_SILENT];
  assign loopback_enable_on = test_on && diag_q[`CIDM_DIAG_LOOPBACK_ENABLE];
  assign basic_on = test_on && diag_q[`CIDM_DIAG_BASIC];
  assign txo = test_on ? cidm_pkg::cidm_txo_e'(diag_q[`CIDM_DIAG_TX_LO +: 2])
                       : cidm_pkg::TXO_NORMAL;

  // Protocol drive: silent or combined mode keeps pin recessive
  assign tx_proto = silent_on ? 1'b1 : CORE_TX;

  // Transmit pin source select
  always_comb begin
    case (txo)
      cidm_pkg::TXO_NORMAL: CAN_TX = tx_proto;
      cidm_pkg::TXO_SAMPLE: CAN_TX = CORE_SAMPLE_PT;
      cidm_pkg::TXO_LOW: CAN_TX = 1'b0;
      cidm_pkg::TXO_HIGH: CAN_TX = 1'b1;
      default: CAN_TX = tx_proto;
    endcase
  end

  // Receive path into the controller
  always_comb begin
    if (loopback_enable_on) begin
      CORE_RX = CORE_TX;
    end else if (silent_on) begin
      CORE_RX = CAN_RX & CORE_TX;
    end else begin
      CORE_RX = CAN_RX;
    end
  end

  assign CORE_SILENT = silent_on;
  assign CORE_ACK_IGNORE = loopback_enable_on;
  assign BASIC_MODE = basic_on;
  assign BASIC_TX_REQ = basic_on && (btx_q == cidm_pkg::BTX_PEND);
  assign BASIC_RETRY_EN = basic_on && (btx_q != cidm_pkg::BTX_IDLE);
  assign IF1_DATA = if1_q;

  // Identifier: status source ranks first, then lowest object
  always_comb begin
    if (sts_irq_q) begin
      interrupt_identifier = `CIDM_INTERRUPT_IDENTIFIER_STATUS;
    end else if (pend_any) begin
      interrupt_identifier = 16'(pend_top) + 16'h0001;
    end else begin
      interrupt_identifier = `CIDM_INTERRUPT_IDENTIFIER_NONE;
    end
  end

  // Line follows identifier, gated by enable only
  assign IRQ = ctrl_q[`CIDM_CTRL_IE] && (interrupt_identifier != `CIDM_INTERRUPT_IDENTIFIER_NONE);

  assign sts_read = rd_go && (S_AXI_ARADDR == `CIDM_OFS_STATUS);
  // Command-mask clear is not evaluated in basic mode
  assign pclr_en = wr_go && !basic_on && (S_AXI_AWADDR == `CIDM_OFS_IF_CMD) &&
                   S_AXI_WSTRB[1] && S_AXI_WDATA[`CIDM_CMD_CLRPND];
  assign pclr_idx = S_AXI_WDATA[IW-1:0];

  // Object pending flags and priority encoder
  cidm_pend_map #(.NOBJ(NOBJ), .IW(IW)) u_pend (
    .clk(REF_CLK),
    .rst_n(NRST),
    .set_en(OBJ_IRQ_SET),
    .set_idx(OBJ_IRQ_IDX),
    .clr_en(pclr_en),
    .clr_idx(pclr_idx),
    .clr_all(sts_read),
    .map_q(pend_map),
    .any_q(pend_any),
    .top_q(pend_top)
  );

  // Read value mux
  always_comb begin
    rd_val = 32'h0000_0000;
    case (S_AXI_ARADDR)
      `CIDM_OFS_CTRL: rd_val = {24'h000000, ctrl_q};
      `CIDM_OFS_STATUS: rd_val = {24'h000000, sts_q};
      `CIDM_OFS_INTERRUPT_IDENTIFIER: rd_val = {16'h0000, interrupt_identifier};
      `CIDM_OFS_DIAG: rd_val = {24'h000000, CAN_RX, diag_q[6:0]};
      `CIDM_OFS_PEND: rd_val = 32'(pend_map);
      `CIDM_OFS_IF1_REQ: rd_val = {16'h0000, btx_q != cidm_pkg::BTX_IDLE, 15'h0000};
      `CIDM_OFS_IF1_DATA: rd_val = if1_q;
      `CIDM_OFS_IF2_REQ: rd_val = 32'h0000_0000;
      `CIDM_OFS_IF2_MCTL: rd_val = {16'h0000, new_data_flag_q, message_lost_flag_q, 10'h000, dlc_q};
      `CIDM_OFS_IF2_DATA: rd_val = if2_q;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // AXI next state
  always_comb begin
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (bvalid_q && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d = is_mapped(S_AXI_AWADDR) ? `CIDM_RESP_OKAY : `CIDM_RESP_SLVERR;
    end
    if (rvalid_q && S_AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
    if (rd_go) begin
      rvalid_d = 1'b1;
      rdata_d = rd_val;
      rresp_d = is_mapped(S_AXI_ARADDR) ? `CIDM_RESP_OKAY : `CIDM_RESP_SLVERR;
    end
  end

  // AXI registers
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      bvalid_q <= 1'b0;
      bresp_q <= `CIDM_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `CIDM_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // Control, status, diagnostic and interface next state
  always_comb begin
    ctrl_d = ctrl_q;
    sts_d = sts_q;
    sts_irq_d = sts_irq_q;
    diag_d = diag_q;
    if1_d = if1_q;
    if2_d = if2_q;
    dlc_d = dlc_q;
    new_data_flag_d = new_data_flag_q;
    message_lost_flag_d = message_lost_flag_q;
    btx_d = btx_q;
    wmask = 32'h0000_0000;
    // Software writes
    if (wr_go) begin
      case (S_AXI_AWADDR)
        `CIDM_OFS_CTRL: begin
          wmask = merge_strb({24'h000000, ctrl_q}, S_AXI_WDATA, S_AXI_WSTRB);
          ctrl_d = wmask[7:0];
        end
        `CIDM_OFS_STATUS: begin
          // Only success and error-code fields are writable
          wmask = merge_strb({24'h000000, sts_q}, S_AXI_WDATA, S_AXI_WSTRB);
          sts_d[4:0] = wmask[4:0];
        end
        `CIDM_OFS_DIAG: begin
          wmask = merge_strb({24'h000000, diag_q}, S_AXI_WDATA, S_AXI_WSTRB);
          diag_d = {1'b0, wmask[6:0]};
        end
        `CIDM_OFS_IF1_DATA: begin
          // Locked while a transmission is pending
          if (btx_q == cidm_pkg::BTX_IDLE) begin
            if1_d = merge_strb(if1_q, S_AXI_WDATA, S_AXI_WSTRB);
          end
        end
        `CIDM_OFS_IF1_REQ: begin
          if (S_AXI_WSTRB[1] && basic_on) begin
            if (S_AXI_WDATA[`CIDM_REQ_BUSY]) begin
              if (btx_q == cidm_pkg::BTX_IDLE) begin
                btx_d = cidm_pkg::BTX_PEND;
              end
            end else begin
              btx_d = cidm_pkg::BTX_IDLE;
            end
          end
        end
        `CIDM_OFS_IF2_REQ: begin
          // Busy request copies the live shift register
          if (S_AXI_WSTRB[1] && basic_on && S_AXI_WDATA[`CIDM_REQ_BUSY]) begin
            if2_d = SHIFT_DATA;
            dlc_d = SHIFT_DLC;
          end
        end
        `CIDM_OFS_IF2_MCTL: begin
          if (S_AXI_WSTRB[1]) begin
            new_data_flag_d = S_AXI_WDATA[`CIDM_MCTL_NEW_DATA_FLAG];
            message_lost_flag_d = S_AXI_WDATA[`CIDM_MCTL_MESSAGE_LOST_FLAG];
          end
        end
        default: begin
        end
      endcase
    end
    // Status read clears the status source
    if (sts_read) begin
      sts_irq_d = 1'b0;
    end
    // Engine status update overrides software and raises source if its enable is set
    if (STS_UPD) begin
      sts_d = {STS_BUS_OFF_FLAG, STS_ERROR_WARNING_FLAG, 1'b0, STS_RX_SUCCESS_FLAG, STS_TX_SUCCESS_FLAG, STS_LEC};
      if (STS_UPD_ERR ? ctrl_q[`CIDM_CTRL_EIE] : ctrl_q[`CIDM_CTRL_SIE]) begin
        sts_irq_d = 1'b1;
      end
    end
    // Basic transmit sequence
    if (!basic_on) begin
      btx_d = cidm_pkg::BTX_IDLE;
    end else begin
      case (btx_q)
        cidm_pkg::BTX_PEND: begin
          // An abort in the same cycle beats the load
          if (BASIC_TX_LOAD && btx_d == cidm_pkg::BTX_PEND) begin
            btx_d = cidm_pkg::BTX_SHIFT;
          end
        end
        cidm_pkg::BTX_SHIFT: begin
          if (BASIC_TX_DONE) begin
            btx_d = cidm_pkg::BTX_IDLE;
          end else if (BASIC_TX_FAIL && btx_d != cidm_pkg::BTX_IDLE) begin
            btx_d = cidm_pkg::BTX_PEND;
          end
        end
        cidm_pkg::BTX_IDLE: begin
        end
        default: btx_d = cidm_pkg::BTX_IDLE;
      endcase
    end
    // In basic mode every received frame lands in set two unfiltered
    if (basic_on && BASIC_RX_DONE) begin
      if2_d = SHIFT_DATA;
      dlc_d = SHIFT_DLC;
      message_lost_flag_d = message_lost_flag_q | new_data_flag_q;
      new_data_flag_d = 1'b1;
    end
  end

  // Register update
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_q <= `CIDM_RST_CTRL;
      sts_q <= `CIDM_RST_STATUS;
      sts_irq_q <= 1'b0;
      diag_q <= `CIDM_RST_DIAG;
      if1_q <= 32'h0000_0000;
      if2_q <= 32'h0000_0000;
      dlc_q <= 4'h0;
      new_data_flag_q <= 1'b0;
      message_lost_flag_q <= 1'b0;
      btx_q <= cidm_pkg::BTX_IDLE;
    end else begin
      ctrl_q <= ctrl_d;
      sts_q <= sts_d;
      sts_irq_q <= sts_irq_d;
      diag_q <= diag_d;
      if1_q <= if1_d;
      if2_q <= if2_d;
      dlc_q <= dlc_d;
      new_data_flag_q <= new_data_flag_d;
      message_lost_flag_q <= message_lost_flag_d;
      btx_q <= btx_d;
    end
  end

endmodule

// ==== design/cidm_cfg.svh ====
// Purpose: Offsets, field positions, reset values of the CAN irq/diag block
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: Definitions only
`ifndef CIDM_CFG_SVH
`define CIDM_CFG_SVH

// Register byte offsets
`define CIDM_OFS_CTRL 8'h00
`define CIDM_OFS_STATUS 8'h04
`define CIDM_OFS_INTERRUPT_IDENTIFIER 8'h08
`define CIDM_OFS_DIAG 8'h0C
`define CIDM_OFS_PEND 8'h10
`define CIDM_OFS_IF1_REQ 8'h14
`define CIDM_OFS_IF1_DATA 8'h18
`define CIDM_OFS_IF2_REQ 8'h1C
`define CIDM_OFS_IF2_MCTL 8'h20
`define CIDM_OFS_IF2_DATA 8'h24
`define CIDM_OFS_IF_CMD 8'h28

// Control register fields
`define CIDM_CTRL_IE 0
`define CIDM_CTRL_SIE 1
`define CIDM_CTRL_EIE 2
`define CIDM_CTRL_TEST 7

// Status register fields
`define CIDM_STS_LEC_LO 0
`define CIDM_STS_TX_SUCCESS_FLAG 3
`define CIDM_STS_RX_SUCCESS_FLAG 4
`define CIDM_STS_ERROR_WARNING_FLAG 6
`define CIDM_STS_BUS_OFF_FLAG 7

// Diagnostic register fields
`define CIDM_DIAG_BASIC 2
`define CIDM_DIAG_SILENT 3
`define CIDM_DIAG_LOOPBACK_ENABLE 4
`define CIDM_DIAG_TX_LO 5
`define CIDM_DIAG_RX 7

// Interface fields
`define CIDM_REQ_BUSY 15
`define CIDM_MCTL_NEW_DATA_FLAG 15
`define CIDM_MCTL_MESSAGE_LOST_FLAG 14
`define CIDM_CMD_CLRPND 8

// Identifier values and reset values
`define CIDM_INTERRUPT_IDENTIFIER_STATUS 16'h8000
`define CIDM_INTERRUPT_IDENTIFIER_NONE 16'h0000
`define CIDM_RST_CTRL 8'h00
`define CIDM_RST_DIAG 8'h00
`define CIDM_RST_STATUS 8'h07

// AXI responses
`define CIDM_RESP_OKAY 2'b00
`define CIDM_RESP_SLVERR 2'b10

`endif

// ==== design/cidm_pkg.sv ====
// Purpose: Types of the CAN irq/diag block
// Assumes: Nothing
// Notes: Constants live in cidm_cfg.svh
package cidm_pkg;

  // Transmit pin source selection
  typedef enum logic [1:0] {
    TXO_NORMAL = 2'b00,
    TXO_SAMPLE = 2'b01,
    TXO_LOW = 2'b10,
    TXO_HIGH = 2'b11
  } cidm_txo_e;

  // Buffer-only transmit sequence
  typedef enum logic [1:0] {
    BTX_IDLE = 2'b00,
    BTX_PEND = 2'b01,
    BTX_SHIFT = 2'b10
  } cidm_btx_e;

endpackage

// ==== design/cidm_pend_map.sv ====
// Purpose: Per-object pending flags with registered priority encoder
// Assumes: Object number is index plus one
// Notes: Set wins over any clear in the same cycle
`timescale 1ns/1ps
module cidm_pend_map #(
  parameter int NOBJ = 32,
  parameter int IW = 5
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, low
  input wire logic set_en, // Set pulse
  input wire logic [IW-1:0] set_idx, // Index to set
  input wire logic clr_en, // Clear pulse
  input wire logic [IW-1:0] clr_idx, // Index to clear
  input wire logic clr_all, // Clear every flag
  output logic [NOBJ-1:0] map_q, // Pending flags
  output logic any_q, // Some flag pending
  output logic [IW-1:0] top_q // Lowest pending index
);

  logic [NOBJ-1:0] map_d; // Next flags
  logic any_d; // Next any
  logic [IW-1:0] top_d; // Next lowest index

  // Next flags, then lowest set index wins
  always_comb begin
    map_d = map_q;
    if (clr_all) begin
      map_d = '0;
    end
    if (clr_en) begin
      map_d[clr_idx] = 1'b0;
    end
    if (set_en) begin
      map_d[set_idx] = 1'b1;
    end
    any_d = |map_d;
    top_d = '0;
    for (int i = NOBJ - 1; i >= 0; i--) begin
      if (map_d[i]) begin
        top_d = IW'(i);
      end
    end
  end

  // Register flags and encoder result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map_q <= '0;
      any_q <= 1'b0;
      top_q <= '0;
    end else begin
      map_q <= map_d;
      any_q <= any_d;
      top_q <= top_d;
    end
  end

endmodule

// ==== sim/cidm_top_sva.sv ====
// Purpose: Port-level checks of the CAN irq/diag block
// Assumes: One clock domain, reset active low
// Notes: Attached by bind from the bench top file
`timescale 1ns/1ps
module cidm_top_sva #(
  parameter int NOBJ = 32, // Message objects
  parameter int IW = 5 // Object index width
) (
  input wire logic REF_CLK, // Clock
  input wire logic NRST, // Async reset, low
  input wire logic [7:0] S_AXI_ARADDR, // Read address
  input wire logic S_AXI_ARVALID, // Read address valid
  input wire logic S_AXI_ARREADY, // Read address ready
  input wire logic [31:0] S_AXI_RDATA, // Read data
  input wire logic S_AXI_AWVALID, // Write address valid
  input wire logic S_AXI_AWREADY, // Write address ready
  input wire logic IRQ, // Interrupt line
  input wire logic STS_UPD, // Status update
  input wire logic OBJ_IRQ_SET, // Object irq set
  input wire logic CORE_TX, // Controller bit
  input wire logic CORE_RX, // Bit to controller
  input wire logic CORE_SILENT, // Silent flag
  input wire logic CORE_ACK_IGNORE, // Loopback flag
  input wire logic CAN_RX, // Receive pin
  input wire logic CAN_TX, // Transmit pin
  input wire logic BASIC_TX_REQ, // Set one pending
  input wire logic BASIC_RETRY_EN, // Send under way
  input wire logic BASIC_TX_LOAD, // Loaded at idle
  input wire logic BASIC_TX_DONE // Completed
);
  // Shared clock and reset for every property
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  // Write taken this cycle
  logic wr_take;
  assign wr_take = S_AXI_AWVALID && S_AXI_AWREADY;

  AST_IRQ_ID: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h08 && IRQ
    |=> S_AXI_RDATA[15:0] != 16'h0000) else $error("irq with zero identifier");
  AST_STS_READ_CLR: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h04 && !STS_UPD && !OBJ_IRQ_SET
    |=> !IRQ) else $error("status read left irq");
  AST_DIAG_RX: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h0C
    |=> S_AXI_RDATA[7] == $past(CAN_RX)) else $error("rx pin bit wrong");
  AST_SILENT_TX: assert property (
    CORE_SILENT |-> CAN_TX) else $error("silent drove dominant");
  AST_LB_ROUTE: assert property (
    CORE_ACK_IGNORE |-> CORE_RX == CORE_TX) else $error("loopback not routed");
  AST_SILENT_RX: assert property (
    CORE_SILENT && !CORE_ACK_IGNORE |-> CORE_RX == (CAN_RX & CORE_TX))
    else $error("silent rx wrong");
  AST_NORMAL_RX: assert property (
    !CORE_SILENT && !CORE_ACK_IGNORE |-> CORE_RX == CAN_RX) else $error("rx not pin");
  AST_BASIC_LOAD: assert property (
    BASIC_TX_REQ && BASIC_TX_LOAD && !wr_take |=> !BASIC_TX_REQ && BASIC_RETRY_EN)
    else $error("load not taken");
  AST_BASIC_DONE: assert property (
    !BASIC_TX_REQ && BASIC_RETRY_EN && BASIC_TX_DONE && !wr_take |=> !BASIC_RETRY_EN)
    else $error("done not released");
endmodule

// ==== sim/cidm_bus_model.sv ====
// Purpose: CAN bus seen through a transceiver
// Assumes: Wired-AND, recessive high
// Notes: Another node may pull the bus dominant
`timescale 1ns/1ps
module cidm_bus_model (
  input wire logic can_tx, // Our transmit pin
  input wire logic node_dom, // Other node drives dominant
  output logic can_rx // Bus level back to us
);
  // Dominant wins; bus recessive when nobody pulls it
  assign can_rx = can_tx & ~node_dom;
endmodule

// ==== sim/cidm_top_tb_top.sv ====
// Purpose: Self-checking bench of the CAN irq/diag block
// Assumes: AXI4-Lite master tasks, 40 MHz clock
// Notes: Events are one-cycle pulses
`timescale 1ns/1ps
module cidm_top_tb_top;
  logic clk = 1'b0, nrst = 1'b0; // Clock, reset
  logic [7:0] awaddr = '0, araddr = '0; // Addresses
  logic [31:0] wdata = '0, rdata, x, shd = '0, if1; // Data
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0; // Handshakes
  logic awr, wrd, bvalid, arready, rvalid, irq; // Slave side
  logic [1:0] bresp, rresp, rsp, ov; // Responses
  logic [5:0] ev = '0; // Event pulses
  logic [4:0] oidx = '0; // Object index
  logic [7:0] sv = '0; // Status fields
  logic serr = 0, ctx = 0, samp = 0, dom = 0, canrx, cantx; // Pins
  logic corerx, sil_o, ack_o, basic, txreq, retry, etx, erx, t, lb, sl; // Outputs
  logic [8:0] e; // Test bit and diag value
  int n_fail = 0, n_checks = 0; // Counters
  localparam logic [8:0] DT [8] = '{9'h100, 9'h108, 9'h110, 9'h118, 9'h120, 9'h140,
    9'h160, 9'h018};

  // Free running clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  cidm_top i_cidm_top (.REF_CLK(clk), .NRST(nrst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IRQ(irq), .STS_UPD(ev[0]),
    .STS_UPD_ERR(serr), .STS_LEC(sv[2:0]), .STS_TX_SUCCESS_FLAG(sv[3]), .STS_RX_SUCCESS_FLAG(sv[4]),
    .STS_ERROR_WARNING_FLAG(sv[6]), .STS_BUS_OFF_FLAG(sv[7]), .OBJ_IRQ_SET(ev[1]), .OBJ_IRQ_IDX(oidx),
    .CORE_TX(ctx), .CORE_SAMPLE_PT(samp), .CORE_RX(corerx), .CORE_SILENT(sil_o),
    .CORE_ACK_IGNORE(ack_o), .CAN_RX(canrx), .CAN_TX(cantx), .BASIC_MODE(basic),
    .BASIC_TX_REQ(txreq), .BASIC_RETRY_EN(retry), .IF1_DATA(if1), .BASIC_TX_LOAD(ev[2]),
    .BASIC_TX_DONE(ev[3]), .BASIC_TX_FAIL(ev[4]), .BASIC_RX_DONE(ev[5]),
    .SHIFT_DATA(shd), .SHIFT_DLC(shd[3:0]));
  cidm_bus_model i_cidm_bus_model (.can_tx(cantx), .node_dom(dom), .can_rx(canrx));

  // Compare and count
  task automatic ck(input logic [31:0] g, input logic [31:0] ex);
    n_checks++;
    if (g !== ex) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, ex);
    end
  endtask

  // AXI write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
    do @(negedge clk); while ((awr & wrd) !== 1'b1);
    @(posedge clk);
    awv <= 0; wv <= 0;
    do @(negedge clk); while (bvalid !== 1'b1);
    rsp = bresp;
    @(posedge clk);
    bready <= 0;
  endtask

  // AXI read
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arv <= 1; rready <= 1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arv <= 0;
    do @(negedge clk); while (rvalid !== 1'b1);
    x = rdata; rsp = rresp;
    @(posedge clk);
    rready <= 0;
  endtask

  // Read and compare
  task automatic cr(input logic [7:0] a, input logic [31:0] ex);
    rd(a);
    ck(x, ex);
  endtask

  // One-cycle event pulse, settled after
  task automatic evp(input int i);
    @(posedge clk);
    ev[i] <= 1;
    @(posedge clk);
    ev <= '0;
    @(negedge clk);
  endtask

  // Object irq and status update
  task automatic obj(input logic [4:0] i);
    @(posedge clk); oidx <= i; evp(1);
  endtask
  task automatic sts(input logic er, input logic [7:0] v);
    @(posedge clk); serr <= er; sv <= v; evp(0);
  endtask

  // Verdict and end of run
  task automatic test_done;
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    #(25.0 * 20000);
    n_fail++;
    test_done;
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    cr(8'h04, 32'h07); ck(cantx, ctx);
    cr(8'h08, 0); ck(irq, 0); ck(rsp, 2'b00);
    obj(4); obj(1); cr(8'h08, 2);
    cr(8'h10, 32'h12); ck(irq, 0);
    wr(8'h00, 32'h07); ck(irq, 1); ck(rsp, 2'b00);
    sts(0, 8'h07); cr(8'h08, 32'h8000);
    cr(8'h04, 32'h07); cr(8'h08, 0); ck(irq, 0);
    obj(2); obj(5); wr(8'h28, 32'h102); cr(8'h08, 6);
    wr(8'h28, 32'h105); cr(8'h08, 0);
    wr(8'h00, 32'h01); sts(0, 8'h0F); cr(8'h08, 0);
    sts(1, 8'h4F); cr(8'h08, 0);
    wr(8'h00, 32'h05); sts(1, 8'hCF); cr(8'h08, 32'h8000);
    wr(8'h04, 0); cr(8'h08, 32'h8000);
    cr(8'h04, 32'hC0); cr(8'h08, 0);
    wr(8'h3C, 32'hFF); ck(rsp, 2'b10); rd(8'h3C); ck(rsp, 2'b10);
    // Diagnostic modes over every core bit and bus level combination
    for (int k = 0; k < 8; k++) begin
      e = DT[k];
      wr(8'h00, {24'h0, e[8], 7'h0});
      wr(8'h0C, {25'h0, e[6:0]});
      t = e[8]; lb = t & e[4]; sl = t & e[3]; ov = t ? e[6:5] : 2'd0;
      for (int j = 0; j < 4; j++) begin
        @(posedge clk);
        ctx <= j[0]; dom <= j[1]; samp <= ~j[0];
        @(negedge clk);
        etx = sl ? 1'b1 : (ov == 2'd0 ? ctx : (ov == 2'd1 ? samp : ov[0]));
        erx = etx & ~dom;
        ck(cantx, etx);
        ck(corerx, lb ? ctx : (sl ? erx & ctx : erx));
        ck({sil_o, ack_o}, {sl, lb});
        if (t) cr(8'h0C, {24'h0, erx, e[6:0]});
      end
    end
    // Buffer-only transmit and receive
    wr(8'h00, 32'h80); wr(8'h0C, 32'h04); ck(basic, 1);
    obj(3); wr(8'h28, 32'h103); cr(8'h08, 4);
    wr(8'h18, 32'hA5A50001); wr(8'h14, 32'h8000); ck(txreq, 1);
    wr(8'h18, 0); ck(if1, 32'hA5A50001);
    evp(2); ck({txreq, retry}, 2'b01);
    evp(4); ck(txreq, 1);
    evp(2); evp(3); ck(retry, 0); cr(8'h14, 0);
    wr(8'h14, 32'h8000); evp(2); wr(8'h14, 0); ck(retry, 0);
    evp(4); ck(txreq, 0);
    @(posedge clk); shd <= 32'h12345678; evp(5);
    cr(8'h24, 32'h12345678); cr(8'h20, 32'h8008);
    evp(5); cr(8'h20, 32'hC008);
    @(posedge clk); shd <= 32'h0BADF00D;
    wr(8'h1C, 32'h8000); cr(8'h24, 32'h0BADF00D); cr(8'h20, 32'hC00D);
    wr(8'h00, 0); ck(basic, 0);
    test_done;
  end
endmodule

bind cidm_top cidm_top_sva #(.NOBJ(NOBJ), .IW(IW)) i_cidm_top_sva (.REF_CLK(REF_CLK),
  .NRST(NRST), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .IRQ(IRQ), .STS_UPD(STS_UPD), .OBJ_IRQ_SET(OBJ_IRQ_SET),
  .CORE_TX(CORE_TX), .CORE_RX(CORE_RX), .CORE_SILENT(CORE_SILENT),
  .CORE_ACK_IGNORE(CORE_ACK_IGNORE), .CAN_RX(CAN_RX), .CAN_TX(CAN_TX),
  .BASIC_TX_REQ(BASIC_TX_REQ), .BASIC_RETRY_EN(BASIC_RETRY_EN),
  .BASIC_TX_LOAD(BASIC_TX_LOAD), .BASIC_TX_DONE(BASIC_TX_DONE));
